// ---- verilog/gpio_pin_pkg.sv ----
// Purpose: Shared constants for the general purpose pin block
// Assumes: 8-bit register port with 8-bit register addresses
// Notes: Register offsets are byte addresses on the internal register port
package gpio_pin_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_COUNT = 7;
  localparam int unsigned OPEN_DRAIN_PIN = 3;

  // Register offsets
  localparam logic [7:0] PIN_LEVEL_READBACK_ADDR = 8'h0E;
  localparam logic [7:0] PIN_INPUT_DISABLE_ADDR = 8'h0F;
  localparam logic [7:0] PIN_OUTPUT_CONFIG_BASE = 8'h10;
  localparam logic [7:0] PIN_OUTPUT_CONFIG_LAST = 8'h16;
  localparam logic [7:0] PIN_PULLDOWN_DISABLE_ADDR = 8'hBE;

  // Reset values
  localparam logic [7:0] INPUT_DISABLE_RESET = 8'h00;
  localparam logic [7:0] PULLDOWN_DISABLE_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // Per-pin output configuration byte layout
  localparam int unsigned FUNC_SEL_HI = 7;
  localparam int unsigned FUNC_SEL_LO = 5;
  localparam int unsigned SRC_SEL_HI = 4;
  localparam int unsigned SRC_SEL_LO = 2;
  localparam int unsigned OUT_LEVEL_BIT = 1;
  localparam int unsigned OUT_ENABLE_BIT = 0;

  // Output source groups
  localparam logic [2:0] SRC_RX_PORT0 = 3'h0;
  localparam logic [2:0] SRC_RX_PORT1 = 3'h1;
  localparam logic [2:0] SRC_DEVICE_STATUS = 3'h4;

  // Function codes inside a receive port group
  localparam logic [2:0] FUNC_FWD_PIN0 = 3'h0;
  localparam logic [2:0] FUNC_FWD_PIN1 = 3'h1;
  localparam logic [2:0] FUNC_FWD_PIN2 = 3'h2;
  localparam logic [2:0] FUNC_FWD_PIN3 = 3'h3;
  localparam logic [2:0] FUNC_LOCK = 3'h4;
  localparam logic [2:0] FUNC_PASS = 3'h5;
  localparam logic [2:0] FUNC_FRAME_VALID = 3'h6;
  localparam logic [2:0] FUNC_LINE_VALID = 3'h7;

  // Function code inside the device status group
  localparam logic [2:0] FUNC_REG_LEVEL = 3'h0;

endpackage : gpio_pin_pkg

// ---- verilog/gpio_pin_control.sv ----
// Purpose: Seven general purpose pins with output source control, and input and pulldown control on all but pin 3
// Assumes: Register port runs on clock_i; pin levels arrive asynchronously
// Notes: Pin 3 is open drain and also carries the active-low device interrupt
module gpio_pin_control #(
  parameter int unsigned NUM_PINS = gpio_pin_pkg::PIN_COUNT,
  parameter int unsigned OD_PIN = gpio_pin_pkg::OPEN_DRAIN_PIN
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Internal register port from the serial control slave
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Receive port 0 status and forwarded remote pins
  input wire logic [3:0] rx0_fwd_pins_i,
  input wire logic rx0_lock_i,
  input wire logic rx0_pass_i,
  input wire logic rx0_frame_valid_i,
  input wire logic rx0_line_valid_signal_i,
  // Receive port 1 status and forwarded remote pins
  input wire logic [3:0] rx1_fwd_pins_i,
  input wire logic rx1_lock_i,
  input wire logic rx1_pass_i,
  input wire logic rx1_frame_valid_i,
  input wire logic rx1_line_valid_signal_i,
  // Device interrupt request, active high, shared onto pin 3
  input wire logic dev_irq_i,
  // Pad side
  input wire logic [NUM_PINS-1:0] pin_i,
  output logic [NUM_PINS-1:0] pin_o,
  output logic [NUM_PINS-1:0] pin_oe_o,
  output logic [NUM_PINS-1:0] pin_pulldown_en_o,
  output logic [NUM_PINS-1:0] pin_input_en_o,
  // Qualified input levels toward the back channel
  output logic [NUM_PINS-1:0] pin_in_level_o,
  // Level seen on the shared interrupt pin, active low
  output logic interrupt_pin_n_o
);

  // Refused at elaboration: the register map serves exactly seven pins
  if (NUM_PINS != gpio_pin_pkg::PIN_COUNT)
  begin : g_bad_count
    $error("NUM_PINS must equal the seven pins the register map serves");
  end
  if (OD_PIN >= NUM_PINS)
  begin : g_bad_od
    $error("OD_PIN must name one of the pins");
  end

  // Drive decision for one pin: bit 1 is drive enable, bit 0 is level
  function automatic logic [1:0] select_drive(
    input logic [7:0] cfg,
    input logic [7:0] rx0_vec,
    input logic [7:0] rx1_vec
  );
    logic [2:0] src;
    logic [2:0] func;
    logic [1:0] res;
    src = cfg[gpio_pin_pkg::SRC_SEL_HI:gpio_pin_pkg::SRC_SEL_LO];
    func = cfg[gpio_pin_pkg::FUNC_SEL_HI:gpio_pin_pkg::FUNC_SEL_LO];
    res = 2'b00;
    if (!cfg[gpio_pin_pkg::OUT_ENABLE_BIT])
    begin
      res = 2'b00;
    end
    else if (src == gpio_pin_pkg::SRC_RX_PORT0)
    begin
      res = {1'b1, rx0_vec[func]};
    end
    else if (src == gpio_pin_pkg::SRC_RX_PORT1)
    begin
      res = {1'b1, rx1_vec[func]};
    end
    else if (src == gpio_pin_pkg::SRC_DEVICE_STATUS && func == gpio_pin_pkg::FUNC_REG_LEVEL)
    begin
      res = {1'b1, cfg[gpio_pin_pkg::OUT_LEVEL_BIT]};
    end
    else
    begin
      // Other groups are not served here; keeping the pad off avoids garbage
      res = 2'b00;
    end
    return res;
  endfunction

  // Pin number addressed by a config register offset, or NUM_PINS if none
  function automatic int unsigned cfg_index(input logic [7:0] addr);
    int unsigned idx;
    idx = NUM_PINS;
    if (addr >= gpio_pin_pkg::PIN_OUTPUT_CONFIG_BASE &&
        addr <= gpio_pin_pkg::PIN_OUTPUT_CONFIG_LAST)
    begin
      idx = 32'(addr - gpio_pin_pkg::PIN_OUTPUT_CONFIG_BASE);
    end
    return idx;
  endfunction

  // Bits that exist for a pin-per-bit control register
  localparam logic [7:0] CTRL_MASK = 8'h7F & ~(8'h01 << OD_PIN);

  logic [NUM_PINS-1:0] pin_meta_q;
  logic [NUM_PINS-1:0] pin_sync_q;
  logic [7:0] input_disable_q;
  logic [7:0] pulldown_disable_q;
  logic [7:0] out_cfg_q [NUM_PINS];
  logic [NUM_PINS-1:0] drive_en_d;
  logic [NUM_PINS-1:0] drive_lvl_d;
  logic [NUM_PINS-1:0] pin_q;
  logic [NUM_PINS-1:0] pin_oe_q;
  logic [7:0] rx0_vec;
  logic [7:0] rx1_vec;
  logic [7:0] rdata_d;
  logic irq_q;

  // Function code order of each receive port group
  assign rx0_vec = {rx0_line_valid_signal_i, rx0_frame_valid_i, rx0_pass_i, rx0_lock_i,
                    rx0_fwd_pins_i};
  assign rx1_vec = {rx1_line_valid_signal_i, rx1_frame_valid_i, rx1_pass_i, rx1_lock_i,
                    rx1_fwd_pins_i};

  // Pad levels are asynchronous; two flops before anything reads them
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Input-disable register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      input_disable_q <= gpio_pin_pkg::INPUT_DISABLE_RESET;
    end
    else if (reg_wr_i && reg_addr_i == gpio_pin_pkg::PIN_INPUT_DISABLE_ADDR)
    begin
      input_disable_q <= reg_wdata_i & CTRL_MASK;
    end
  end

  // Pulldown-disable register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pulldown_disable_q <= gpio_pin_pkg::PULLDOWN_DISABLE_RESET;
    end
    else if (reg_wr_i && reg_addr_i == gpio_pin_pkg::PIN_PULLDOWN_DISABLE_ADDR)
    begin
      pulldown_disable_q <= reg_wdata_i & CTRL_MASK;
    end
  end

  // Per-pin output configuration bytes and drive selection
  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++)
    begin : g_pin
      logic [1:0] sel;

      always_ff @(posedge clock_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          out_cfg_q[g] <= gpio_pin_pkg::OUTPUT_CONFIG_RESET;
        end
        else if (reg_wr_i && cfg_index(reg_addr_i) == g)
        begin
          out_cfg_q[g] <= reg_wdata_i;
        end
      end

      assign sel = select_drive(out_cfg_q[g], rx0_vec, rx1_vec);

      if (g == OD_PIN)
      begin : g_od
        // Open drain: pull low for the interrupt or a low selected level
        assign drive_en_d[g] = dev_irq_i || (sel[1] && !sel[0]);
        assign drive_lvl_d[g] = 1'b0;
        assign pin_pulldown_en_o[g] = 1'b0;
        assign pin_input_en_o[g] = 1'b1;
      end
      else
      begin : g_pp
        assign drive_en_d[g] = sel[1];
        assign drive_lvl_d[g] = sel[0];
        assign pin_pulldown_en_o[g] = !pulldown_disable_q[g];
        assign pin_input_en_o[g] = !input_disable_q[g];
      end
    end
  endgenerate

  // Pad drive is registered so the pad never sees decode glitches
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_q <= '0;
      pin_oe_q <= '0;
    end
    else
    begin
      pin_q <= drive_lvl_d;
      pin_oe_q <= drive_en_d;
    end
  end

  assign pin_o = pin_q;
  assign pin_oe_o = pin_oe_q;

  // Back channel sees a pin only while its input path is enabled
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_in_level_o <= '0;
    end
    else
    begin
      pin_in_level_o <= pin_sync_q & pin_input_en_o;
    end
  end

  // Shared interrupt pin level as seen on the pad
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_q <= 1'b1;
    end
    else
    begin
      irq_q <= pin_sync_q[OD_PIN];
    end
  end

  assign interrupt_pin_n_o = irq_q;

  // Register read decode
  always_comb
  begin
    rdata_d = gpio_pin_pkg::READ_UNMAPPED;
    if (reg_addr_i == gpio_pin_pkg::PIN_LEVEL_READBACK_ADDR)
    begin
      // Pad level regardless of direction or input enable
      rdata_d = 8'(pin_sync_q);
    end
    else if (reg_addr_i == gpio_pin_pkg::PIN_INPUT_DISABLE_ADDR)
    begin
      rdata_d = input_disable_q;
    end
    else if (reg_addr_i == gpio_pin_pkg::PIN_PULLDOWN_DISABLE_ADDR)
    begin
      rdata_d = pulldown_disable_q;
    end
    else if (cfg_index(reg_addr_i) < NUM_PINS)
    begin
      rdata_d = out_cfg_q[cfg_index(reg_addr_i)];
    end
    else
    begin
      rdata_d = gpio_pin_pkg::READ_UNMAPPED;
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= gpio_pin_pkg::READ_UNMAPPED;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i)
      begin
        reg_rdata_o <= rdata_d;
      end
    end
  end

endmodule // gpio_pin_control

// ---- dv/gpio_pin_properties.sv ----
// Purpose: Port assertions for the general purpose pin block
// Assumes: Single clock_i domain, rst_n_i active low
// Notes: Pin 0 carries the output configuration checks, pin 1 the input and pulldown disable checks
module gpio_pin_checker #(
  parameter int unsigned NUM_PINS = 7
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic dev_irq_i,
  input wire logic [NUM_PINS-1:0] pin_o,
  input wire logic [NUM_PINS-1:0] pin_oe_o,
  input wire logic [NUM_PINS-1:0] pin_pulldown_en_o,
  input wire logic [NUM_PINS-1:0] pin_input_en_o,
  input wire logic [NUM_PINS-1:0] pin_in_level_o
);
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  // A second write to the same place would mask the first, so it is excluded
  sequence wr_then_hold(logic [7:0] a, logic [7:0] m, logic [7:0] v);
    reg_wr_i && reg_addr_i == a && (reg_wdata_i & m) == v ##1 !(reg_wr_i && reg_addr_i == a);
  endsequence
  sequence rd_at(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  // Exact byte: other function codes in the status group sharing the low bits must stay undriven
  property reg_level_p;
    wr_then_hold(8'h10, 8'hFF, 8'h13) |=> pin_oe_o[0] && pin_o[0];
  endproperty
  property en_off_p;
    wr_then_hold(8'h10, 8'h01, 8'h00) |=> !pin_oe_o[0];
  endproperty
  property in_disable_p;
    wr_then_hold(8'h0F, 8'h02, 8'h02) |-> !pin_input_en_o[1];
  endproperty
  property pd_disable_p;
    wr_then_hold(8'hBE, 8'h02, 8'h02) |-> !pin_pulldown_en_o[1];
  endproperty
  property od_pin_p;
    !pin_o[3] && !pin_pulldown_en_o[3] && pin_input_en_o[3];
  endproperty
  rd_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read not answered");
  unmapped_zero_a: assert property (rd_at(8'h40) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  od_never_high_a: assert property (od_pin_p)
    else $error("open drain pin misbehaves");
  irq_pulls_low_a: assert property (dev_irq_i |=> pin_oe_o[3])
    else $error("interrupt not on shared pin");
  en_off_idle_a: assert property (en_off_p)
    else $error("pin driven while disabled");
  reg_level_a: assert property (reg_level_p)
    else $error("register level not driven");
  in_disable_a: assert property (in_disable_p)
    else $error("input disable bit ignored");
  pd_disable_a: assert property (pd_disable_p)
    else $error("pulldown disable bit ignored");
  in_gate_a: assert property (!pin_input_en_o[0] |=> !pin_in_level_o[0])
    else $error("disabled input passes level");
endmodule // gpio_pin_checker

bind gpio_pin_control gpio_pin_checker #(.NUM_PINS(NUM_PINS)) i_chk (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .dev_irq_i(dev_irq_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
  .pin_pulldown_en_o(pin_pulldown_en_o), .pin_input_en_o(pin_input_en_o),
  .pin_in_level_o(pin_in_level_o));

// ---- dv/board_model.sv ----
// Purpose: Board pads around the seven pins
// Assumes: Pull-up on the shared interrupt line only
// Notes: A floating pad toggles so it never reads as a steady level
module board_model (
  input wire logic clock_i,
  input wire logic [6:0] pin_o,
  input wire logic [6:0] pin_oe_o,
  input wire logic [6:0] pin_pulldown_en_o,
  input wire logic [6:0] ext_en_i,
  input wire logic [6:0] ext_level_i,
  output logic [6:0] pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] float_q = 7'h2A;
  always @(posedge clock_i) float_q <= ~float_q;
  always_comb
    for (int i = 0; i < 7; i++)
      if (pin_oe_o[i]) pin_i[i] = (i == 3) ? 1'b0 : pin_o[i];
      else if (ext_en_i[i]) pin_i[i] = ext_level_i[i];
      else if (i == 3) pin_i[i] = 1'b1;
      else if (pin_pulldown_en_o[i]) pin_i[i] = 1'b0;
      else pin_i[i] = float_q[i];
endmodule // board_model

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the general purpose pin block
// Assumes: Register port pulses one cycle per access
// Notes: Receive port inputs are driven straight from the bench
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r0 = 8'h00, r1 = 8'h00;
  logic wr = 1'b0, rd = 1'b0, rvalid, irq = 1'b0, int_n;
  logic [6:0] pin_i, pin_o, oe, pd, ien, lvl, ext_en = 7'h00, ext_lv = 7'h00;
  logic [7:0] cfgs [7] = '{8'h13, 8'h12, 8'h09, 8'h31, 8'h1D, 8'h15, 8'h11};
  logic [7:0] exps [7] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
  int fails = 0, checked = 0, cyc = 0;
  always #10 clock_i = ~clock_i;
  gpio_pin_control i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .rx0_fwd_pins_i(r0[3:0]), .rx0_lock_i(r0[4]), .rx0_pass_i(r0[5]),
    .rx0_frame_valid_i(r0[6]), .rx0_line_valid_signal_i(r0[7]), .rx1_fwd_pins_i(r1[3:0]),
    .rx1_lock_i(r1[4]), .rx1_pass_i(r1[5]), .rx1_frame_valid_i(r1[6]),
    .rx1_line_valid_signal_i(r1[7]), .dev_irq_i(irq), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(oe), .pin_pulldown_en_o(pd), .pin_input_en_o(ien), .pin_in_level_o(lvl),
    .interrupt_pin_n_o(int_n));
  board_model i_board (.clock_i(clock_i), .pin_o(pin_o), .pin_oe_o(oe),
    .pin_pulldown_en_o(pd), .ext_en_i(ext_en), .ext_level_i(ext_lv), .pin_i(pin_i));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    chk({7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask
  // Pad levels pass two sync flops, so three edges leave margin
  task automatic settle;
    repeat (3) @(posedge clock_i);
    #1;
  endtask
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    logic [7:0] v;
    logic [7:0] e;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    chk({1'b0, ien}, 8'h7F);
    chk({1'b0, pd}, 8'h77);
    chk({1'b0, oe}, 8'h00);
    for (int a = 8'h0F; a <= 8'h16; a++)
    begin
      rd_reg(a[7:0], v);
      chk(v, 8'h00);
    end
    rd_reg(8'hBE, v);
    chk(v, 8'h00);
    $display("done reset");
    wr_reg(8'h0F, 8'hFF);
    wr_reg(8'hBE, 8'hFF);
    wr_reg(8'h0E, 8'hFF);
    rd_reg(8'h0F, v);
    chk(v, 8'h77);
    rd_reg(8'hBE, v);
    chk(v, 8'h77);
    chk({1'b0, ien}, 8'h08);
    chk({1'b0, pd}, 8'h00);
    rd_reg(8'h40, v);
    chk(v, 8'h00);
    @(posedge clock_i);
    ext_en <= 7'h7F;
    ext_lv <= 7'h55;
    settle;
    rd_reg(8'h0E, v);
    chk(v, 8'h55);
    chk({1'b0, lvl}, 8'h00);
    // Inputs briefly enabled so the gated level is seen passing as well
    wr_reg(8'h0F, 8'h00);
    settle;
    chk({1'b0, lvl}, 8'h55);
    wr_reg(8'h0F, 8'hFF);
    $display("done registers");
    for (int s = 0; s < 2; s++)
      for (int f = 0; f < 8; f++)
      begin
        @(posedge clock_i);
        r0 <= 8'h96;
        r1 <= 8'h69;
        wr_reg(8'h10, {f[2:0], s[2:0], 2'b01});
        settle;
        e = (s != 0) ? 8'h69 : 8'h96;
        chk({6'h00, oe[0], pin_o[0]}, {6'h00, 1'b1, e[f]});
        @(posedge clock_i);
        r0 <= 8'h69;
        r1 <= 8'h96;
        settle;
        chk({6'h00, oe[0], pin_o[0]}, {6'h00, 1'b1, ~e[f]});
      end
    for (int k = 0; k < 7; k++)
    begin
      wr_reg(8'h10, cfgs[k]);
      settle;
      chk({6'h00, oe[0], oe[0] & pin_o[0]}, exps[k]);
    end
    rd_reg(8'h0E, v);
    chk(v, 8'h54);
    $display("done functions");
    for (int p = 0; p < 7; p++)
      wr_reg(8'h10 + p[7:0], 8'h13);
    settle;
    chk({1'b0, oe}, 8'h77);
    chk({1'b0, pin_o}, 8'h77);
    @(posedge clock_i);
    ext_en <= 7'h77;
    wr_reg(8'h13, 8'h11);
    settle;
    settle;
    chk({6'h00, oe[3], int_n}, 8'h02);
    wr_reg(8'h13, 8'h00);
    irq <= 1'b1;
    settle;
    settle;
    chk({6'h00, oe[3], int_n}, 8'h02);
    @(posedge clock_i);
    irq <= 1'b0;
    settle;
    settle;
    chk({6'h00, oe[3], int_n}, 8'h01);
    $display("done open drain");
    conclude();
  end
endmodule // tb
